/* hw/ccms_pkg.sv */
// package: constants for the cpu clock mode select block
package ccms_pkg;
  localparam int unsigned CFG_W            = 3;
  localparam logic [2:0]  CFG_PRESCALE     = 3'h1;  // divide by two
  localparam logic [2:0]  CFG_DIRECT       = 3'h3;  // direct drive, pll off
  localparam logic [2:0]  CFG_RST_VAL      = 3'h7;  // pins float high without pull-downs
  localparam int unsigned SYNC_STAGES      = 2;
  localparam real         CLK_PERIOD_NS    = 10.0;
  localparam real         OSC_PERIOD_MIN_NS = 31.0; // fastest input in prescaler mode
  localparam int unsigned OSC_MIN_CYCLES   = (OSC_PERIOD_MIN_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
                                             int'($floor(OSC_PERIOD_MIN_NS / CLK_PERIOD_NS));
  typedef enum logic [2:0] {
    CCMS_MODE_NONE     = 3'b001,
    CCMS_MODE_PRESCALE = 3'b010,
    CCMS_MODE_DIRECT   = 3'b100
  } ccms_mode_t;
endpackage

/* hw/ccms_sync.sv */
// two-stage synchroniser for pin levels
module ccms_sync
  import ccms_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else if (i_ce) begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;
endmodule // ccms_sync

/* hw/ccms_top.sv */
// cpu clock generator with reset-time mode selection
// How it works
// RULE1: mode code is taken from three config pins while reset is active.
// RULE2: code 001 gives cpu clock at half the oscillator rate.
// RULE3: in prescaler mode each phase lasts one full oscillator period.
// RULE4: code 011 disables pll and runs cpu clock straight from oscillator.
// RULE5: in direct mode cpu phases follow oscillator high and low times.
// RULE6: in direct mode two consecutive phases span one oscillator period.
// RULE7: board must present only 001 or 011; other codes are reserved.
// RULE8: both cpu clock edges are flagged as phase events.
// RULE9: mode latched at reset release and held until next reset.
module ccms_top
  import ccms_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_oscillator_input,
  input  wire logic [CFG_W-1:0] i_clock_mode_config_pins,
  output logic                  o_cpu_clk,
  output logic                  o_clock_phase_edge,
  output logic                  o_clock_phase_rise,
  output logic                  o_pll_enable,
  output logic                  o_mode_prescale,
  output logic                  o_mode_direct,
  output logic                  o_mode_reserved,
  output logic [CFG_W-1:0]      o_clock_mode_config_bits
);
  logic [CFG_W-1:0] cfg_sync;
  logic             osc_sync;
  logic             mode_prescale_reg;
  logic             mode_direct_reg;
  logic             mode_reserved_reg;
  logic             pll_en_reg;
  logic             osc_prev_reg;
  logic             cpu_clk_reg;
  logic             cpu_clk_next;
  logic             edge_reg;
  logic             rise_reg;
  logic [CFG_W-1:0] cfg_reg;
  ccms_mode_t       mode_reg;
  ccms_mode_t       mode_next;
  logic             osc_rise;
  logic             mode_locked_reg;

  // pins come from the board, so both pass two flops first
  ccms_sync #(.W(CFG_W + 1)) u_sync (
    .i_clk (i_clk),
    .i_rst (1'b0),
    .i_ce  (i_ce),
    .i_d   ({i_clock_mode_config_pins, i_oscillator_input}),
    .o_q   ({cfg_sync, osc_sync})
  );

  // decode of the code sampled under reset; reserved codes leave the clock stopped
  // limitation: the oscillator is sampled, so each of its phases needs one system clock or more
  assign osc_rise  = osc_sync & ~osc_prev_reg;
  assign mode_next = (cfg_reg == CFG_PRESCALE) ? CCMS_MODE_PRESCALE :  // RULE2
                     (cfg_reg == CFG_DIRECT)   ? CCMS_MODE_DIRECT   :  // RULE4
                                                  CCMS_MODE_NONE;       // RULE7
  always_comb begin
    unique case (mode_reg)
      CCMS_MODE_PRESCALE: cpu_clk_next = osc_rise ? ~cpu_clk_reg : cpu_clk_reg;  // RULE3
      CCMS_MODE_DIRECT:   cpu_clk_next = osc_sync;                               // RULE5 RULE6
      CCMS_MODE_NONE:     cpu_clk_next = 1'b0;
    endcase
  end

  // the sampler runs during reset itself; an async reset would hide the pins
  always_ff @(posedge i_clk) begin
    if (i_ce && i_rst) begin
      cfg_reg <= cfg_sync;  // RULE1
    end
  end

  // mode is taken from the last value seen under reset and then frozen;
  // the flags are registered copies so every mode output leaves a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg          <= CCMS_MODE_NONE;
      mode_locked_reg   <= 1'b0;
      mode_prescale_reg <= 1'b0;
      mode_direct_reg   <= 1'b0;
      mode_reserved_reg <= 1'b1;
      pll_en_reg        <= 1'b0;
    end else if (i_ce) begin
      pll_en_reg <= 1'b0;  // RULE4
      if (!mode_locked_reg) begin
        mode_reg          <= mode_next;  // RULE9
        mode_prescale_reg <= mode_next == CCMS_MODE_PRESCALE;
        mode_direct_reg   <= mode_next == CCMS_MODE_DIRECT;
        mode_reserved_reg <= mode_next == CCMS_MODE_NONE;
        mode_locked_reg   <= 1'b1;  // RULE9
      end
    end
  end

  // clock and phase-edge outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_prev_reg <= 1'b0;
      cpu_clk_reg  <= 1'b0;
      edge_reg     <= 1'b0;
      rise_reg     <= 1'b0;
    end else if (i_ce) begin
      osc_prev_reg <= osc_sync;
      cpu_clk_reg  <= cpu_clk_next;
      edge_reg     <= cpu_clk_next ^ cpu_clk_reg;     // RULE8
      rise_reg     <= cpu_clk_next & ~cpu_clk_reg;    // RULE8
    end
  end

  assign o_cpu_clk                = cpu_clk_reg;
  assign o_clock_phase_edge       = edge_reg;
  assign o_clock_phase_rise       = rise_reg;
  assign o_pll_enable             = pll_en_reg;  // RULE4
  assign o_mode_prescale          = mode_prescale_reg;
  assign o_mode_direct            = mode_direct_reg;
  assign o_mode_reserved          = mode_reserved_reg;
  assign o_clock_mode_config_bits = cfg_reg;

  // assertions
  sequence s_osc_rise;
    osc_sync && !osc_prev_reg;
  endsequence

  AST_PRESC_TOGGLE: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE3
    ((i_ce && mode_reg == CCMS_MODE_PRESCALE) and s_osc_rise) |=> (cpu_clk_reg != $past(cpu_clk_reg)))
    else $error("prescaler did not toggle on oscillator rise");
  AST_PRESC_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE2
    (i_ce && mode_reg == CCMS_MODE_PRESCALE && !(osc_sync && !osc_prev_reg)) |=> $stable(cpu_clk_reg))
    else $error("prescaler clock changed without oscillator rise");
  AST_DIRECT_FOLLOW: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE5
    (i_ce && mode_reg == CCMS_MODE_DIRECT) |=> (cpu_clk_reg == $past(osc_sync)))
    else $error("direct clock does not follow oscillator");
  AST_DIRECT_PAIR: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE6
    ((i_ce && mode_reg == CCMS_MODE_DIRECT) and s_osc_rise) |=> (cpu_clk_reg && rise_reg))
    else $error("direct pair not aligned to oscillator period");
  AST_PLL_OFF: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE4
    o_mode_direct |-> !o_pll_enable)
    else $error("pll enabled in direct mode");
  AST_RESERVED_STOP: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE7
    (i_ce && mode_reg == CCMS_MODE_NONE) |=> !cpu_clk_reg)
    else $error("clock runs in reserved mode");
  AST_EDGE_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE8
    (i_ce && $past(i_ce) && cpu_clk_reg != $past(cpu_clk_reg)) |-> edge_reg)
    else $error("phase edge not flagged");
  AST_MODE_HELD: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE9
    mode_locked_reg |=> $stable(mode_reg))
    else $error("mode changed after lock");
  AST_MODE_FROM_CFG: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE1
    (i_ce && !mode_locked_reg && cfg_reg == CFG_DIRECT) |=> (mode_reg == CCMS_MODE_DIRECT))
    else $error("mode not taken from sampled code");

  // named steps reused by the checks below
  // lock step: the first enabled edge after reset release
  sequence s_lock_edge;
    i_ce && !mode_locked_reg;
  endsequence

  // reset seen at one edge, released with the clock running at the next
  sequence s_release;
    i_rst ##1 (!i_rst && i_ce);
  endsequence

  // a cpu clock edge launched at the previous enabled edge
  sequence s_cpu_edge;
    $past(i_ce) && (cpu_clk_reg != $past(cpu_clk_reg));
  endsequence

  // mode selection and lock
  // every code lands in exactly one mode, reserved ones included
  AST_MODE_PRESC_CFG: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE2
    (s_lock_edge and (cfg_reg == CFG_PRESCALE)) |=> (mode_reg == CCMS_MODE_PRESCALE))
    else $error("prescaler mode not taken from sampled code");
  AST_MODE_RSVD_CFG: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE7
    (s_lock_edge and (cfg_reg != CFG_PRESCALE && cfg_reg != CFG_DIRECT)) |=> (mode_reg == CCMS_MODE_NONE))
    else $error("reserved code did not select the stopped mode");
  AST_LOCK_AFTER_RELEASE: assert property (@(posedge i_clk)  // RULE9
    s_release |=> mode_locked_reg)
    else $error("mode not locked after reset release");
  AST_RESET_QUIET: assert property (@(posedge i_clk)  // RULE1
    i_rst |-> (!cpu_clk_reg && !edge_reg && !rise_reg && !mode_locked_reg && mode_reserved_reg))
    else $error("generator active during reset");

  // nothing on the pins can move the mode once it is locked
  AST_CFG_HELD: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE9
    mode_locked_reg |=> $stable(cfg_reg))
    else $error("sampled code changed after reset");
  AST_FLAGS_HELD: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE9
    mode_locked_reg |=> ($stable(mode_prescale_reg) && $stable(mode_direct_reg) && $stable(mode_reserved_reg)))
    else $error("mode flags changed after lock");
  AST_FLAGS_ONEHOT: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE9
    mode_locked_reg |-> $onehot({mode_prescale_reg, mode_direct_reg, mode_reserved_reg}))
    else $error("mode flags not one-hot");
  AST_FLAGS_MATCH: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE9
    mode_locked_reg |-> (mode_direct_reg == (mode_reg == CCMS_MODE_DIRECT)))
    else $error("mode flags disagree with mode");
  AST_PLL_NEVER: assert property (@(posedge i_clk)  // RULE4
    !o_pll_enable)
    else $error("pll enabled");

  // phase event flags track every cpu clock edge and nothing else;
  // downstream logic acts on both edges, so a lost or extra flag skews its timing
  AST_RISE_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE8
    (s_cpu_edge and cpu_clk_reg) |-> rise_reg)
    else $error("rising phase edge not flagged");
  AST_FALL_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE8
    (s_cpu_edge and !cpu_clk_reg) |-> (edge_reg && !rise_reg))
    else $error("falling phase edge flagged wrongly");
  AST_NO_SPURIOUS_EDGE: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE8
    ($past(i_ce) && $stable(cpu_clk_reg)) |-> !edge_reg)
    else $error("phase edge flagged without clock change");
  AST_RESERVED_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE7
    (i_ce && mode_reg == CCMS_MODE_NONE) |=> !edge_reg)
    else $error("phase edge in reserved mode");

  // a low clock enable must freeze the generator, not just its outputs
  AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (i_rst)  // RULE8
    !i_ce |=> ($stable(cpu_clk_reg) && $stable(edge_reg) && $stable(rise_reg) && $stable(mode_reg)))
    else $error("state moved while clock enable low");
endmodule // ccms_top

/* bench/ccms_osc_model.sv */
// behavioural oscillator source for the oscillator input
module ccms_osc_model (
  input  var int i_hi,
  input  var int i_lo,
  output logic   o_osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running source; edges sit 1 ns past the rising clock edge, like every other input
  initial begin
    o_osc = 1'b0;
    #6;
    forever begin
      o_osc = 1'b1;
      #(i_hi * 10);
      o_osc = 1'b0;
      #(i_lo * 10);
    end
  end
endmodule  // ccms_osc_model

/* bench/tb_top.sv */
// self-checking bench for the cpu clock mode select block
module tb_top
  import ccms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             rst = 1'b0;  // rises in the first run so the async reset sees an edge
  logic             ce = 1'b1;
  logic [CFG_W-1:0] pins = CFG_PRESCALE;
  logic             osc, cpu, edg, rise, pll, mp, md, mr;
  logic [CFG_W-1:0] bits;
  int               hi = 5, lo = 5, ne = 0, nr = 0, num_errors = 0, n_tests = 0;
  logic [31:0]      seed = 32'h0000_b63e;
  logic [2:0]       tab [6] = '{3'h1, 3'h3, 3'h7, 3'h1, 3'h3, 3'h3};
  // clock and devices
  initial forever #5 clk = ~clk;
  ccms_osc_model u_ccms_osc_model (.i_hi(hi), .i_lo(lo), .o_osc(osc));
  ccms_top u_ccms_top (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_oscillator_input(osc),
    .i_clock_mode_config_pins(pins), .o_cpu_clk(cpu), .o_clock_phase_edge(edg), .o_clock_phase_rise(rise),
    .o_pll_enable(pll), .o_mode_prescale(mp), .o_mode_direct(md), .o_mode_reserved(mr),
    .o_clock_mode_config_bits(bits));
  // phase event counters, cleared by the scenario
  always @(posedge clk) if (edg === 1'b1) ne++;
  always @(posedge clk) if (rise === 1'b1) nr++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected {reserved, direct, prescale} for a strap code
  function automatic logic [2:0] exp_mode(input logic [2:0] c);
    return {c != CFG_PRESCALE && c != CFG_DIRECT, c == CFG_DIRECT, c == CFG_PRESCALE};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // cycles until the cpu clock changes; a stopped clock gives the 300 limit
  task automatic ph(output int n);
    logic v;
    v = cpu;
    n = 0;
    while (cpu === v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one boot with a strap code, random oscillator shape, then strap noise
  task automatic run(input logic [2:0] code);
    int p1, p2;
    logic v;
    hi = rnd() % 8 + 4;
    lo = rnd() % 8 + 4;
    pins = code;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1 pins = CFG_W'(rnd());
    chk({mr, md, mp}, exp_mode(code));
    chk(bits, code);
    chk(pll, 1'b0);
    ph(p1);
    ph(p1);
    ne = 0;
    nr = 0;
    ph(p1);
    ph(p2);
    chk({mr, md, mp}, exp_mode(code));
    chk(ne, exp_mode(code) == 3'h4 ? 0 : 2);
    chk(nr, exp_mode(code) == 3'h4 ? 0 : 1);
    if (code == CFG_PRESCALE) begin
      chk(p1, hi + lo);
      chk(p2, hi + lo);
    end else if (code == CFG_DIRECT) begin
      chk(p1 + p2, hi + lo);
      chk(p1 == hi ? p2 : p1, lo);
    end else begin
      chk(p1, 300);
      chk(cpu, 1'b0);
    end
    chk(bits, code);
    // clock enable low: generator and phase flags freeze, mode stays
    @(posedge clk);
    #1 ce = 1'b0;
    v = cpu;
    ne = 0;
    repeat (20) @(posedge clk);
    #1 chk(cpu, v);
    chk(ne, 0);
    chk({mr, md, mp}, exp_mode(code));
    ce = 1'b1;
    $display("test code %h done", code);
  endtask
  initial begin
    #1;
    foreach (tab[i]) run(tab[i]);
    report_and_stop();
  end
  // watchdog well beyond the expected run length
  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end
endmodule  // tb_top
